// File: acr_core.sv
// Register file, trigger, compare and conversion clock logic of the converter
//
// How it works
// RULE1: Active flag set on start, cleared done/abort
// RULE2: Trigger select: register write or hardware input
// RULE3: Compare enable bit gates compare function
// RULE4: Compare direction: less-than or greater-equal
// RULE5: Software writes zero to reserved bits
// RULE6: High byte holds upper bits, rest zero
// RULE7: Results load unless compare fails
// RULE8: Stored compare result is result minus value
// RULE9: High read locks results until low read
// RULE10: No lock in eight-bit mode
// RULE11: Width change invalidates both result bytes
// RULE12: Low byte holds lower eight result bits
// RULE13: Compare high bits used per width
// RULE14: Compare low byte always compared
// RULE15: Low-power bit selects reduced-power setting
// RULE16: Divider field gives ratio 1,2,4,8
// RULE17: Sample bit selects short or long
// RULE18: Width field selects 8, 12, 10 bit
// RULE19: Clock field selects one of four sources
// RULE20: First control write aborts and restarts
// RULE21: Complete flag cleared by write or low read
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "acr_defs.svh"
module acr_core
    import acr_pkg::*;
(
    input  wire logic        clk,                  // Bus clock, 25 MHz
    input  wire logic        rst_b,                // Synchronous reset, active low
    input  wire logic [4:0]  address,              // Avalon byte address
    input  wire logic        read,                 // Avalon read request
    input  wire logic        write,                // Avalon write request
    input  wire logic [31:0] writedata,            // Avalon write data
    output logic [31:0]      readdata,             // Avalon read data
    output logic             waitrequest,          // Avalon stall
    input  wire logic        hardware_trigger_in,  // Hardware conversion trigger
    input  wire logic        alternate_clock,      // Alternate source clock level
    input  wire logic        converter_async_clock, // Converter own clock level
    output logic             conv_start,           // One-cycle start to analog core
    output logic             conv_abort,           // One-cycle abort to analog core
    input  wire logic        conv_done,            // One-cycle completion from core
    input  wire logic [11:0] conv_result,          // Raw result, right aligned
    output logic             conversion_clock,     // One-cycle conversion clock tick
    output logic [4:0]       channel_select,       // Selected input channel
    output logic [1:0]       conv_width,           // Width code to core
    output logic             low_power_select,     // Reduced-power setting
    output logic             long_sample_select    // Long sample period
);
    // ======================================================================
    // Registers
    logic [7:0]  sc1_r;
    acr_sc2_s    sc2_r;
    acr_cfg_s    cfg_r;
    logic [7:0]  cvh_r;
    logic [7:0]  cvl_r;
    logic [11:0] result_r;
    logic        conversion_complete_flag_r;
    logic        lock_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        start_r;
    logic        abort_r;
    logic        trg_q_r;
    logic        alt_q_r;
    logic        asy_q_r;
    logic        half_r;
    logic [2:0]  div_cnt_r;
    logic        tick_r;

    // ======================================================================
    // Bus decode: one wait state, access takes effect when ack_r is high
    wire req      = read | write;
    wire acc_wr   = write & ack_r;
    wire acc_rd   = read & ack_r;
    wire wr_sc1   = acc_wr & (address == `ACR_OFF_SC1);
    wire wr_sc2   = acc_wr & (address == `ACR_OFF_SC2);
    wire wr_cvh   = acc_wr & (address == `ACR_OFF_CVH);
    wire wr_cvl   = acc_wr & (address == `ACR_OFF_CVL);
    wire wr_cfg   = acc_wr & (address == `ACR_OFF_CFG);
    wire mode8    = (cfg_r.conv_width == `ACR_MODE_8);
    wire rd_rh    = acc_rd & (address == `ACR_OFF_RH);
    wire rd_rl    = acc_rd & (address == `ACR_OFF_RL);
    wire [7:0] wd = writedata[7:0];
    assign waitrequest = req & ~ack_r;

    // Read mux; unmapped offsets read as zero
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (address)
            `ACR_OFF_SC1: rd_mux = {conversion_complete_flag_r, sc1_r[6:0]};
            `ACR_OFF_SC2: rd_mux = {sc2_r[7:4], 4'h0};
            `ACR_OFF_RH:  rd_mux = {4'h0, result_r[11:8]};   // RULE6
            `ACR_OFF_RL:  rd_mux = result_r[7:0];            // RULE12
            `ACR_OFF_CVH: rd_mux = cvh_r;
            `ACR_OFF_CVL: rd_mux = cvl_r;
            `ACR_OFF_CFG: rd_mux = cfg_r;
            default:      rd_mux = 8'h00;
        endcase
    end

    // Handshake and read data registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r   <= req & ~ack_r;
            rdata_r <= {24'h00_0000, rd_mux};
        end
    end
    assign readdata = rdata_r;

    // ======================================================================
    // Triggers: the channel all-ones code disables the converter
    wire ch_on    = (sc1_r[4:0] != `ACR_CH_OFF);
    wire wr_ch_on = (wd[4:0] != `ACR_CH_OFF);
    wire hw_rise  = hardware_trigger_in & ~trg_q_r;
    wire sw_go    = wr_sc1 & ~sc2_r.trigger_select & wr_ch_on;       // RULE2 RULE20
    wire hw_go    = ~wr_sc1 & sc2_r.trigger_select & ch_on & hw_rise
                    & ~sc2_r.conversion_in_progress;                 // RULE2
    wire cont_go  = conv_done & sc1_r[`ACR_SC1_CONT] & ch_on & ~wr_sc1;
    wire start    = sw_go | hw_go | cont_go;
    wire abort    = wr_sc1 & sc2_r.conversion_in_progress;           // RULE20

    // ======================================================================
    // Compare value and result alignment per width
    logic [11:0] wmask;
    logic [11:0] cmp_val;
    always_comb
    begin
        unique case (cfg_r.conv_width)
            `ACR_MODE_12: wmask = 12'hFFF;
            `ACR_MODE_10: wmask = 12'h3FF;
            default:      wmask = 12'h0FF;
        endcase
        cmp_val = {cvh_r[3:0], cvl_r} & wmask;                       // RULE13 RULE14
    end
    wire [11:0] res_m    = conv_result & wmask;
    wire        lt       = res_m < cmp_val;
    wire        cmp_true = sc2_r.compare_greater_equal ? ~lt : lt;   // RULE4
    wire        cmp_ok   = ~sc2_r.compare_enable | cmp_true;         // RULE3
    wire [11:0] diff     = (res_m - cmp_val) & wmask;                // RULE8
    wire        blocked  = lock_r & ~rd_rl;
    wire        load     = conv_done & sc2_r.conversion_in_progress & ~wr_sc1
                           & cmp_ok & ~blocked;                      // RULE7 RULE9
    wire        mode_chg = wr_cfg & (wd[3:2] != cfg_r.conv_width);

    // ======================================================================
    // Software registers; reserved second-control bits are not stored
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sc1_r <= `ACR_SC1_RST;
            sc2_r <= `ACR_SC2_RST;
            cfg_r <= `ACR_CFG_RST;
            cvh_r <= `ACR_CV_RST;
            cvl_r <= `ACR_CV_RST;
        end
        else
        begin
            if (wr_sc1)
                sc1_r <= wd;
            if (wr_sc2)
                sc2_r[6:4] <= wd[6:4];                               // RULE5
            if (start)
                sc2_r.conversion_in_progress <= 1'b1;                // RULE1
            else if (abort | conv_done)
                sc2_r.conversion_in_progress <= 1'b0;                // RULE1
            if (wr_cfg)
                cfg_r <= wd;                                         // RULE18
            if (wr_cvh)
                cvh_r <= wd;
            if (wr_cvl)
                cvl_r <= wd;
        end
    end

    // Result, complete flag and interlock; a new result beats a flag clear, a width change beats a new result
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            result_r <= 12'h000;
            conversion_complete_flag_r   <= 1'b0;
            lock_r   <= 1'b0;
        end
        else
        begin
            if (mode_chg)
                result_r <= 12'h000;                                 // RULE11
            else if (load)
                result_r <= sc2_r.compare_enable ? diff : res_m;     // RULE6 RULE8
            if (load)
                conversion_complete_flag_r <= 1'b1;
            else if (wr_sc1 | rd_rl)
                conversion_complete_flag_r <= 1'b0;                                      // RULE21
            if (rd_rl | mode_chg)
                lock_r <= 1'b0;
            else if (rd_rh & ~mode8)
                lock_r <= 1'b1;                                      // RULE9 RULE10
        end
    end

    // ======================================================================
    // Conversion clock: source select then divide, issued as a tick
    logic src_tick;
    always_comb
    begin
        unique case (cfg_r.input_clock_select)                       // RULE19
            `ACR_CLK_BUS:   src_tick = 1'b1;
            `ACR_CLK_BUS2:  src_tick = half_r;
            `ACR_CLK_ALT:   src_tick = alternate_clock & ~alt_q_r;
            default:        src_tick = converter_async_clock & ~asy_q_r;
        endcase
    end
    // Ratio minus one is 0, 1, 3 or 7
    wire [2:0] div_top = 3'((4'h1 << cfg_r.clock_divide_select) - 4'h1);
    wire       div_end = src_tick & (div_cnt_r >= div_top);

    // Edge history, divider and pulses to the analog core
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            trg_q_r   <= 1'b0;
            alt_q_r   <= 1'b0;
            asy_q_r   <= 1'b0;
            half_r    <= 1'b0;
            div_cnt_r <= 3'h0;
            tick_r    <= 1'b0;
            start_r   <= 1'b0;
            abort_r   <= 1'b0;
        end
        else
        begin
            trg_q_r <= hardware_trigger_in;
            alt_q_r <= alternate_clock;
            asy_q_r <= converter_async_clock;
            half_r  <= ~half_r;
            if (div_end)
                div_cnt_r <= 3'h0;                                   // RULE16
            else if (src_tick)
                div_cnt_r <= div_cnt_r + 3'h1;
            tick_r  <= div_end;
            start_r <= start;
            abort_r <= abort;
        end
    end

    // Core-facing levels come straight from the registers
    assign conversion_clock   = tick_r;
    assign conv_start         = start_r;
    assign conv_abort         = abort_r;
    assign channel_select     = sc1_r[4:0];
    assign conv_width         = cfg_r.conv_width;                    // RULE18
    assign low_power_select   = cfg_r.low_power_select;              // RULE15
    assign long_sample_select = cfg_r.long_sample_select;            // RULE17

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_rh_locked;
        rd_rh && !mode8;
    endsequence
    sequence s_done_blocked;
        lock_r && conv_done && !rd_rl && !mode_chg;
    endsequence

    property p_act_set;
        start |=> sc2_r.conversion_in_progress ##0 conv_start;
    endproperty
    a_act_set: assert property (p_act_set) else $error("active flag not set"); // RULE1

    property p_act_clr;
        (conv_done || abort) && !start |=> !sc2_r.conversion_in_progress;
    endproperty
    a_act_clr: assert property (p_act_clr) else $error("active flag not cleared"); // RULE1

    property p_sw_start;
        wr_sc1 && !sc2_r.trigger_select && wd[4:0] != `ACR_CH_OFF |=> conv_start;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("no start after write"); // RULE2

    property p_hw_only;
        conv_start && $past(sc2_r.trigger_select) && !$past(conv_done)
            |-> $past(hw_rise) || $past(wr_sc1);
    endproperty
    a_hw_only: assert property (p_hw_only) else $error("start without hw edge"); // RULE2

    property p_cmp_hold;
        conv_done && sc2_r.compare_enable && !cmp_true && !mode_chg
            |=> $stable(result_r);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("failed compare loaded"); // RULE7

    property p_cmp_diff;
        load && sc2_r.compare_enable && !mode_chg
            |=> result_r == (($past(res_m) - $past(cmp_val)) & $past(wmask));
    endproperty
    a_cmp_diff: assert property (p_cmp_diff) else $error("compare result wrong"); // RULE8

    property p_lock_set;
        s_rh_locked |=> lock_r;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("high read did not lock"); // RULE9

    property p_lock;
        s_done_blocked |=> $stable(result_r);
    endproperty
    a_lock: assert property (p_lock) else $error("result moved while locked"); // RULE9

    property p_no_lock8;
        rd_rh && mode8 |=> !lock_r;
    endproperty
    a_no_lock8: assert property (p_no_lock8) else $error("lock in 8-bit mode"); // RULE10

    property p_inval;
        mode_chg |=> result_r == 12'h000;
    endproperty
    a_inval: assert property (p_inval) else $error("result kept on width change"); // RULE11

    property p_width8;
        mode8 && !mode_chg |=> result_r[11:8] == 4'h0;
    endproperty
    a_width8: assert property (p_width8) else $error("upper bits set in 8-bit"); // RULE6

    property p_conversion_complete_flag;
        load |=> conversion_complete_flag_r;
    endproperty
    a_conversion_complete_flag: assert property (p_conversion_complete_flag) else $error("complete flag lost"); // RULE21

    property p_conversion_complete_flag_clr;
        (wr_sc1 || rd_rl) && !load |=> !conversion_complete_flag_r;
    endproperty
    a_conversion_complete_flag_clr: assert property (p_conversion_complete_flag_clr) else $error("complete flag not cleared"); // RULE21

    property p_div8;
        cfg_r.input_clock_select == `ACR_CLK_BUS && cfg_r.clock_divide_select == 2'h3
            && !wr_cfg && conversion_clock |=> !conversion_clock [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 wrong"); // RULE16
endmodule : acr_core

// File: acr_defs.svh
// Offsets, field positions, reset values and codes of the converter control block
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define ACR_OFF_SC1     5'h00
`define ACR_OFF_SC2     5'h04
`define ACR_OFF_RH      5'h08
`define ACR_OFF_RL      5'h0C
`define ACR_OFF_CVH     5'h10
`define ACR_OFF_CVL     5'h14
`define ACR_OFF_CFG     5'h18
// ==========================================================================
// Field positions
`define ACR_SC1_CONVERSION_COMPLETE_FLAG    7
`define ACR_SC1_CONT    5
`define ACR_SC2_ACT     7
`define ACR_SC2_TRG     6
`define ACR_SC2_CFE     5
`define ACR_SC2_CGT     4
// ==========================================================================
// Codes and reset values
`define ACR_MODE_8      2'h0
`define ACR_MODE_12     2'h1
`define ACR_MODE_10     2'h2
`define ACR_CLK_BUS     2'h0
`define ACR_CLK_BUS2    2'h1
`define ACR_CLK_ALT     2'h2
`define ACR_CLK_ASYNC   2'h3
`define ACR_CH_OFF      5'h1F
`define ACR_SC1_RST     8'h1F
`define ACR_SC2_RST     8'h00
`define ACR_CFG_RST     8'h00
`define ACR_CV_RST      8'h00
`endif

// File: acr_pkg.sv
// Types shared by the converter control block
package acr_pkg;
    // ======================================================================
    // Configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       low_power_select;
        logic [1:0] clock_divide_select;
        logic       long_sample_select;
        logic [1:0] conv_width;
        logic [1:0] input_clock_select;
    } acr_cfg_s;

    // Second control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       conversion_in_progress;
        logic       trigger_select;
        logic       compare_enable;
        logic       compare_greater_equal;
        logic [3:0] reserved;
    } acr_sc2_s;
endpackage : acr_pkg

// File: adc_config_result_compare_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "acr_defs.svh"
module adc_config_result_compare_tb
    import acr_pkg::*;
;
    logic        clk, rst_b, read, write, waitrequest;
    logic [4:0]  address, channel_select;
    logic [31:0] writedata, readdata;
    logic        hardware_trigger_in, alternate_clock, converter_async_clock;
    logic        conv_start, conv_abort, conv_done, conversion_clock;
    logic [11:0] conv_result;
    logic [1:0]  conv_width, aclk_cnt;
    logic        low_power_select, long_sample_select;
    int          n_errors, total_checks, n_start, n_abort;
    acr_cfg_s    cfg;

    acr_core dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .hardware_trigger_in(hardware_trigger_in), .alternate_clock(alternate_clock),
        .converter_async_clock(converter_async_clock), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_done(conv_done), .conv_result(conv_result),
        .conversion_clock(conversion_clock), .channel_select(channel_select),
        .conv_width(conv_width), .low_power_select(low_power_select),
        .long_sample_select(long_sample_select));

    // ======================================================================
    // Clock, source clocks and pulse monitor
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Alternate source ticks every 2 cycles, async source every 4
    always @(posedge clk)
    begin
        alternate_clock       <= ~alternate_clock;
        aclk_cnt              <= aclk_cnt + 2'h1;
        converter_async_clock <= aclk_cnt[1];
    end
    // Counting pulses at the falling edge avoids racing the launching edge
    always @(negedge clk)
    begin
        if (conv_start === 1'b1) n_start++;
        if (conv_abort === 1'b1) n_abort++;
    end

    // ======================================================================
    // Shared tasks
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon transfer; returns at the accept edge with the request released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge clk);
        address   <= a;
        write     <= wr;
        read      <= ~wr;
        writedata <= d;
        // Looked at on the rising edge itself, so the pre-edge values are seen
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (i == 20)
        begin
            n_errors++;
            summarize();
        end
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h00_0000, d}, q);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, {24'h00_0000, exp});
    endtask : rdc

    // Core completion pulse with the raw result in the same cycle
    task automatic done(input logic [11:0] res);
        @(posedge clk);
        conv_done   <= 1'b1;
        conv_result <= res;
        @(posedge clk);
        conv_done   <= 1'b0;
        conv_result <= ~res;
        repeat (2) @(posedge clk);
    endtask : done

    // Spacing of conversion clock ticks, taken after two settling ticks
    task automatic gap(input int exp);
        int i, n;
        repeat (2)
        begin
            i = 0;
            do begin @(negedge clk); i++; end while (conversion_clock !== 1'b1 && i < 100);
        end
        n = 0;
        do begin @(negedge clk); n++; end while (conversion_clock !== 1'b1 && n < 100);
        chk(n, exp);
    endtask : gap

    function automatic logic [11:0] mmask(input logic [1:0] m);
        return (m == `ACR_MODE_12) ? 12'h0FFF : (m == `ACR_MODE_10) ? 12'h03FF : 12'h00FF;
    endfunction : mmask

    // ======================================================================
    // Main sequence
    initial
    begin : main
        int          k, i, s0, a0;
        int          per [4];
        logic [1:0]  m, cur;
        logic        cfe, gt, hit;
        logic [11:0] cv, res, msk, prev;
        per = '{1, 2, 2, 4};
        rst_b = 1'b0; address = 5'h00; read = 1'b0; write = 1'b0; writedata = 32'h0;
        hardware_trigger_in = 1'b0; conv_done = 1'b0; conv_result = 12'h000;
        alternate_clock = 1'b0; converter_async_clock = 1'b0; aclk_cnt = 2'h0;
        void'($urandom(32'h6d29));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, read-only and unmapped places
        chk(channel_select, 32'h1F);
        rdc(`ACR_OFF_SC2, `ACR_SC2_RST);
        rdc(`ACR_OFF_CFG, `ACR_CFG_RST);
        rdc(`ACR_OFF_CVH, `ACR_CV_RST);
        wr(5'h1C, 8'hFF);
        rdc(5'h1C, 8'h00);
        wr(`ACR_OFF_SC2, 8'hF0);
        rdc(`ACR_OFF_SC2, 8'h70);
        wr(`ACR_OFF_SC2, 8'h00);
        $display("Test registers done");
        // Every clock source against every divide code
        for (k = 0; k < 16; k++)
        begin
            cfg = acr_cfg_s'($urandom);
            cfg.conv_width = 2'($urandom % 3);
            cfg.clock_divide_select = k[3:2];
            cfg.input_clock_select = k[1:0];
            wr(`ACR_OFF_CFG, cfg);
            rdc(`ACR_OFF_CFG, cfg);
            chk({cfg.low_power_select, cfg.long_sample_select, cfg.conv_width},
                {low_power_select, long_sample_select, conv_width});
            gap(per[k[1:0]] << k[3:2]);
        end
        $display("Test clocks done");
        // Conversions in every width with random compare settings; equal values first
        cur = 2'h3;
        prev = 12'h000;
        for (k = 0; k < 24; k++)
        begin
            m = 2'(k % 3); cfe = $urandom; gt = $urandom; cv = $urandom; res = $urandom;
            if (k < 6) res = cv;
            if (m != cur) prev = 12'h000;
            cur = m;
            cfg = '0;
            cfg.conv_width = m;
            wr(`ACR_OFF_CFG, cfg);
            wr(`ACR_OFF_SC2, {2'b00, cfe, gt, 4'h0});
            wr(`ACR_OFF_CVH, {4'h0, cv[11:8]});
            wr(`ACR_OFF_CVL, cv[7:0]);
            s0 = n_start;
            wr(`ACR_OFF_SC1, 8'h04);
            rdc(`ACR_OFF_SC2, {2'b10, cfe, gt, 4'h0});
            chk(n_start - s0, 1);
            done(res);
            msk = mmask(m);
            hit = gt ? ((res & msk) >= (cv & msk)) : ((res & msk) < (cv & msk));
            if (!cfe || hit) prev = cfe ? (((res & msk) - (cv & msk)) & msk) : (res & msk);
            rdc(`ACR_OFF_SC2, {2'b00, cfe, gt, 4'h0});
            rdc(`ACR_OFF_SC1, {!cfe || hit, 7'h04});
            rdc(`ACR_OFF_RH, {4'h0, prev[11:8]});
            rdc(`ACR_OFF_RL, prev[7:0]);
            rdc(`ACR_OFF_SC1, 8'h04);
        end
        $display("Test compare done");
        // High-byte read locks in 12-bit mode, not in 8-bit mode
        wr(`ACR_OFF_SC2, 8'h00);
        wr(`ACR_OFF_CFG, 8'h04);
        wr(`ACR_OFF_SC1, 8'h04);
        done(12'hA5C);
        rdc(`ACR_OFF_RH, 8'h0A);
        wr(`ACR_OFF_SC1, 8'h04);
        done(12'h3B1);
        rdc(`ACR_OFF_SC1, 8'h04);
        rdc(`ACR_OFF_RL, 8'h5C);
        wr(`ACR_OFF_CFG, 8'h00);
        wr(`ACR_OFF_SC1, 8'h04);
        done(12'hE77);
        rdc(`ACR_OFF_RH, 8'h00);
        wr(`ACR_OFF_SC1, 8'h04);
        done(12'h4C8);
        rdc(`ACR_OFF_RL, 8'hC8);
        wr(`ACR_OFF_CFG, 8'h08);
        rdc(`ACR_OFF_RL, 8'h00);
        $display("Test interlock done");
        // Writes to the first control register abort and restart
        s0 = n_start;
        a0 = n_abort;
        wr(`ACR_OFF_SC1, 8'h02);
        wr(`ACR_OFF_SC1, 8'h03);
        repeat (2) @(posedge clk);
        chk(channel_select, 32'h03);
        chk(n_start - s0, 32'd2);
        chk(n_abort - a0, 32'd1);
        wr(`ACR_OFF_SC1, 8'h1F);
        repeat (3) @(posedge clk);
        chk(n_start - s0, 32'd2);
        chk(n_abort - a0, 32'd2);
        rdc(`ACR_OFF_SC2, 8'h00);
        $display("Test abort done");
        // Hardware trigger mode: register write alone starts nothing
        wr(`ACR_OFF_SC2, 8'h40);
        s0 = n_start;
        wr(`ACR_OFF_SC1, 8'h05);
        repeat (3) @(posedge clk);
        chk(n_start - s0, 0);
        @(posedge clk);
        hardware_trigger_in <= 1'b1;
        for (i = 0; i < 10 && n_start == s0; i++) @(negedge clk);
        chk(n_start - s0, 1);
        @(posedge clk);
        hardware_trigger_in <= 1'b0;
        done(12'h5A5);
        rdc(`ACR_OFF_RL, 8'hA5);
        rdc(`ACR_OFF_SC2, 8'h40);
        $display("Test hardware trigger done");
        // Continuous bit: a completion restarts at once, so the flag stays up
        wr(`ACR_OFF_SC2, 8'h00);
        s0 = n_start;
        wr(`ACR_OFF_SC1, 8'h25);
        done(12'h123);
        chk(n_start - s0, 32'd2);
        rdc(`ACR_OFF_SC2, 8'h80);
        wr(`ACR_OFF_SC1, 8'h1F);
        rdc(`ACR_OFF_SC2, 8'h00);
        $display("Test continuous done");
        summarize();
    end : main
endmodule : adc_config_result_compare_tb
